/* File: design/mlad_defines.svh */
/*
 * Constants of the logic, arithmetic and move decoder: file addresses,
 * status bit positions, reset values and register offsets.
 * Assumes inclusion by bare name from the decoder.
 */
`ifndef MLAD_DEFINES_SVH
`define MLAD_DEFINES_SVH

// Status register layout.
`define MLAD_ST_C 0
`define MLAD_ST_DC 1
`define MLAD_ST_Z 2
`define MLAD_ST_PD 3
`define MLAD_ST_TO 4
`define MLAD_ST_PAGE_LO 5
`define MLAD_STATUS_RST 8'h18

// File register addresses; only status is decoded inside the block.
`define MLAD_FILE_PCL 5'h02
`define MLAD_FILE_STATUS 5'h03
`define MLAD_FILE_BANK 5'h04

// Instruction cycle division in compatible mode.
`define MLAD_DIV_LAST 2'h3

// Register port offsets.
`define MLAD_REG_CTRL 8'h00
`define MLAD_REG_ACC 8'h01
`define MLAD_REG_STATUS 8'h02
`define MLAD_REG_MODE 8'h03
`define MLAD_REG_OPTION 8'h04
`define MLAD_REG_EXEC 8'h05

// Control register fields and reset value.
`define MLAD_CTRL_FAST 0
`define MLAD_CTRL_CF 1
`define MLAD_CTRL_PSA_WDT 2
`define MLAD_CTRL_RST 8'h02

// Mode register upper bits choose the port control transfer.
`define MLAD_PMODE_READ 2'h0
`define MLAD_PMODE_SWAP 2'h1
`define MLAD_PORT_FIRST 3'h5

`endif

/* File: design/mlad_pkg.sv */
/*
 * Types shared by the decoder: the file write carrier and the
 * register port request.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package mlad_pkg;

	// One write toward file register memory.
	typedef struct packed {
		logic we;
		logic [4:0] addr;
		logic [7:0] data;
	} mlad_file_wr_t;

	// One register port access from software.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mlad_reg_req_t;

endpackage : mlad_pkg

`default_nettype wire

/* File: design/mlad_core.sv */
/*
 * Instruction decoder and executor for logic, arithmetic, rotate, bit
 * and move instructions of an 8-bit core with 12-bit instruction words.
 * Assumes a fetch path that offers instructions on the core clock and a
 * file register memory with a combinational read and a clocked write.
 */
`default_nettype none

`include "mlad_defines.svh"

module mlad_core (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [11:0] instr_i,
	input wire logic instr_valid_i,
	output logic instr_ready_o,
	output logic [4:0] file_addr_o,
	input wire logic [7:0] file_rdata_i,
	output mlad_pkg::mlad_file_wr_t file_wr_o,
	output logic wdt_clear_o,
	output logic prescaler_clear_o,
	output logic [2:0] page_select_o,
	input wire mlad_pkg::mlad_reg_req_t reg_req_i,
	output logic [7:0] reg_rdata_o
);

	logic [1:0] div_cnt;
	logic [7:0] ctrl;
	logic [7:0] acc;
	logic [7:0] status;
	logic [3:0] mode;
	logic [7:0] option;
	logic skip_q;
	logic [7:0] ctl_regs [0:15];

	// Instruction cycle strobe; compatible mode takes one word per four
	// clocks so that timing matches the slower original core.
	wire fast_mode = ctrl[`MLAD_CTRL_FAST];
	wire tick = fast_mode | (div_cnt == `MLAD_DIV_LAST);
	wire taken = tick & instr_valid_i;
	wire exec = taken & ~skip_q;
	assign instr_ready_o = tick;

	// Operand fields and the file operand, with a bypass of the write that
	// is still in flight so back to back instructions see fresh data.
	wire [4:0] faddr = instr_i[4:0];
	wire dir_f = instr_i[5];
	wire [7:0] lit = instr_i[7:0];
	wire [2:0] bsel = instr_i[7:5];
	wire byp = file_wr_o.we & (file_wr_o.addr == faddr);
	wire [7:0] mem_val = byp ? file_wr_o.data : file_rdata_i;
	wire is_st = (faddr == `MLAD_FILE_STATUS);
	wire [7:0] fval = is_st ? status : mem_val;
	assign file_addr_o = faddr;

	// Adder paths; a cleared fuse bit chains the carry in.
	wire chain = ~ctrl[`MLAD_CTRL_CF];
	wire cy = status[`MLAD_ST_C];
	wire add_ci = chain & cy;
	wire sub_ci = chain ? cy : 1'b1;
	wire [8:0] add_sum = {1'b0, fval} + {1'b0, acc} + {8'h00, add_ci};
	wire [4:0] add_nib = {1'b0, fval[3:0]} + {1'b0, acc[3:0]} + {4'h0, add_ci};
	wire [8:0] sub_sum = {1'b0, fval} + {1'b0, ~acc} + {8'h00, sub_ci};
	wire [4:0] sub_nib = {1'b0, fval[3:0]} + {1'b0, ~acc[3:0]} + {4'h0, sub_ci};
	wire [7:0] f_inc = fval + 8'h01;
	wire [7:0] f_dec = fval - 8'h01;
	wire bit_val = fval[bsel];

	// Port control target: mode upper bits choose the transfer, lower bits
	// and the opcode choose the register.
	wire [2:0] rx_off = instr_i[2:0] - `MLAD_PORT_FIRST;
	wire [3:0] ctl_idx = {mode[1:0], rx_off[1:0]};
	wire [1:0] pmode = mode[3:2];

	logic [7:0] res;
	logic to_file;
	logic to_acc;
	logic set_z;
	logic skip_set;
	logic [7:0] next_acc;
	logic [7:0] next_status;
	logic [3:0] next_mode;
	logic [7:0] next_option;
	logic wdt_clr;
	logic port_we;

	// Decode and execute one instruction word.
	always_comb begin
		res = fval;
		to_file = 1'b0;
		to_acc = 1'b0;
		set_z = 1'b0;
		skip_set = 1'b0;
		next_status = status;
		next_mode = mode;
		next_option = option;
		wdt_clr = 1'b0;
		port_we = 1'b0;
		next_acc = acc;
		casez (instr_i)
			12'b0000_0000_0010: next_option = acc;
			12'b0000_0000_0100: begin
				wdt_clr = 1'b1;
				next_status[`MLAD_ST_TO] = 1'b1;
				next_status[`MLAD_ST_PD] = 1'b1;
			end
			12'b0000_0000_0101, 12'b0000_0000_0110,
			12'b0000_0000_0111: begin
				// Read, exchange or write a control register.
				res = ctl_regs[ctl_idx];
				to_acc = (pmode == `MLAD_PMODE_READ) ||
					(pmode == `MLAD_PMODE_SWAP);
				port_we = (pmode != `MLAD_PMODE_READ);
			end
			12'b0000_0100_0000: begin
				res = 8'h00;
				to_acc = 1'b1;
				set_z = 1'b1;
			end
			12'b0000_0100_0010: begin
				res = {4'h0, mode};
				to_acc = 1'b1;
			end
			12'b0000_0100_0011: next_mode = acc[3:0];
			12'b0000_0101_????: next_mode = instr_i[3:0];
			12'b0000_001?_????: begin
				res = acc;
				to_file = 1'b1;
			end
			12'b0000_011?_????: begin
				res = 8'h00;
				to_file = 1'b1;
				set_z = 1'b1;
			end
			12'b0000_10??_????: begin
				// Subtraction: no borrow leaves carry set.
				res = sub_sum[7:0];
				to_file = dir_f;
				to_acc = ~dir_f;
				set_z = 1'b1;
				next_status[`MLAD_ST_C] = sub_sum[8];
				next_status[`MLAD_ST_DC] = sub_nib[4];
			end
			12'b0000_11??_????: begin
				res = f_dec;
				to_file = dir_f;
				to_acc = ~dir_f;
				set_z = 1'b1;
			end
			12'b0001_????_????: begin
				to_file = dir_f;
				to_acc = ~dir_f;
				set_z = 1'b1;
				case (instr_i[7:6])
					2'h0: res = acc | fval;
					2'h1: res = acc & fval;
					2'h2: res = acc ^ fval;
					default: begin
						res = add_sum[7:0];
						next_status[`MLAD_ST_C] = add_sum[8];
						next_status[`MLAD_ST_DC] = add_nib[4];
					end
				endcase
			end
			12'b0010_00??_????: begin
				to_file = dir_f;
				to_acc = ~dir_f;
				set_z = 1'b1;
			end
			12'b0010_01??_????: begin
				res = fval ^ 8'hFF;
				to_file = dir_f;
				to_acc = ~dir_f;
				set_z = 1'b1;
			end
			12'b0010_10??_????: begin
				res = f_inc;
				to_file = dir_f;
				to_acc = ~dir_f;
				set_z = 1'b1;
			end
			12'b0010_11??_????: begin
				res = f_dec;
				to_file = dir_f;
				to_acc = ~dir_f;
				skip_set = (f_dec == 8'h00);
			end
			12'b0011_00??_????: begin
				res = {cy, fval[7:1]};
				to_file = dir_f;
				to_acc = ~dir_f;
				next_status[`MLAD_ST_C] = fval[0];
			end
			12'b0011_01??_????: begin
				res = {fval[6:0], cy};
				to_file = dir_f;
				to_acc = ~dir_f;
				next_status[`MLAD_ST_C] = fval[7];
			end
			12'b0011_10??_????: begin
				res = {fval[3:0], fval[7:4]};
				to_file = dir_f;
				to_acc = ~dir_f;
			end
			12'b0011_11??_????: begin
				res = f_inc;
				to_file = dir_f;
				to_acc = ~dir_f;
				skip_set = (f_inc == 8'h00);
			end
			12'b010?_????_????: begin
				res = fval;
				res[bsel] = instr_i[8];
				to_file = 1'b1;
			end
			12'b011?_????_????: begin
				skip_set = (bit_val == instr_i[8]);
			end
			12'b1100_????_????: begin
				res = lit;
				to_acc = 1'b1;
			end
			12'b1101_????_????, 12'b1110_????_????,
			12'b1111_????_????: begin
				to_acc = 1'b1;
				set_z = 1'b1;
				case (instr_i[9:8])
					2'h1: res = acc | lit;
					2'h2: res = acc & lit;
					default: res = acc ^ lit;
				endcase
			end
			default: res = fval;
		endcase
		if (set_z) begin
			next_status[`MLAD_ST_Z] = (res == 8'h00);
		end
		if (to_acc) begin
			next_acc = res;
		end
		// Software writes to status keep the two reset cause flags.
		if (to_file && is_st) begin
			next_status = {res[7:5], next_status[`MLAD_ST_TO],
				next_status[`MLAD_ST_PD], res[2:0]};
		end
	end

	// Instruction divider runs on every clock.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_cnt <= 2'h0;
		end else begin
			div_cnt <= div_cnt + 2'h1;
		end
	end

	// Architectural state updates only for executed instructions.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc <= 8'h00;
			status <= `MLAD_STATUS_RST;
			mode <= 4'h0;
			option <= 8'hFF;
			skip_q <= 1'b0;
		end else if (taken) begin
			skip_q <= exec & skip_set;
			if (exec) begin
				acc <= next_acc;
				status <= next_status;
				mode <= next_mode;
				option <= next_option;
			end
		end
	end

	// File writes and watchdog pulses leave as one-cycle registered strobes.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			file_wr_o <= '0;
			wdt_clear_o <= 1'b0;
			prescaler_clear_o <= 1'b0;
		end else begin
			file_wr_o.we <= exec & to_file & ~is_st;
			file_wr_o.addr <= faddr;
			file_wr_o.data <= res;
			wdt_clear_o <= exec & wdt_clr;
			prescaler_clear_o <= exec & wdt_clr & ctrl[`MLAD_CTRL_PSA_WDT];
		end
	end

	// Control registers hold no reset; they are written before use.
	always_ff @(posedge clk_i) begin
		if (exec && port_we) begin
			ctl_regs[ctl_idx] <= acc;
		end
	end

	assign page_select_o = status[7:5];
	// Register port decode.
	wire [7:0] rd_mux =
		(reg_req_i.addr == `MLAD_REG_CTRL) ? ctrl :
		(reg_req_i.addr == `MLAD_REG_ACC) ? acc :
		(reg_req_i.addr == `MLAD_REG_STATUS) ? status :
		(reg_req_i.addr == `MLAD_REG_MODE) ? {4'h0, mode} :
		(reg_req_i.addr == `MLAD_REG_OPTION) ? option :
		(reg_req_i.addr == `MLAD_REG_EXEC) ? {7'h00, skip_q} : 8'h00;
	wire ctrl_wr = reg_req_i.wr & (reg_req_i.addr == `MLAD_REG_CTRL);

	// Fuse word image and read data, answered one cycle after the strobe.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= `MLAD_CTRL_RST;
			reg_rdata_o <= 8'h00;
		end else begin
			if (ctrl_wr) begin
				ctrl <= {5'h00, reg_req_i.wdata[2:0]};
			end
			reg_rdata_o <= reg_req_i.rd ? rd_mux : 8'h00;
		end
	end

	// Checks.
	wire ex_lit = exec & (instr_i[11:10] == 2'h3) & (instr_i[11:8] != 4'hC);
	wire ex_orw = exec & (instr_i[11:5] == 7'b0001_000);
	wire ex_wdt = exec & (instr_i == 12'h004);
	wire ex_swap = exec & (instr_i[11:6] == 6'b0011_10) & ~is_st;
	wire ex_movl = exec & (instr_i[11:8] == 4'hC);
	wire ex_movm = exec & (instr_i == 12'h042);
	wire ex_inc = exec & (instr_i[11:5] == 7'b0010_101) & ~is_st;
	ready_div_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!fast_mode && tick |=> (fast_mode || !tick) [*3] ##1 tick)
		else $error("compatible mode strobe spacing wrong");
	lit_logic_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ex_lit |=> acc == $past(res) && status[`MLAD_ST_Z] == (acc == 8'h00))
		else $error("literal logic result wrong");
	reg_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ex_orw |=> acc == ($past(acc) | $past(fval)) &&
		status[`MLAD_ST_Z] == (acc == 8'h00))
		else $error("register logic result wrong");
	wdt_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ex_wdt |=> wdt_clear_o && status[`MLAD_ST_TO] && status[`MLAD_ST_PD]
		##1 (!wdt_clear_o || $past(ex_wdt)))
		else $error("watchdog clear wrong");
	skip_arm_a: assert property (@(posedge clk_i) disable iff (rst_i)
		exec && skip_set |=> skip_q)
		else $error("skip not armed");
	skip_nop_a: assert property (@(posedge clk_i) disable iff (rst_i)
		taken && skip_q |=> !file_wr_o.we && $stable(acc) &&
		$stable(status) && !skip_q)
		else $error("skipped instruction had effect");
	swap_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ex_swap |=> $stable(status))
		else $error("swap changed flags");
	mov_lit_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ex_movl |=> acc == $past(lit) && $stable(status))
		else $error("literal load wrong");
	mode_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ex_movm |=> acc[7:4] == 4'h0 && acc[3:0] == mode)
		else $error("mode read wrong");
	inc_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ex_inc |=> file_wr_o.we && file_wr_o.data == $past(f_inc) &&
		status[1:0] == $past(status[1:0]))
		else $error("increment write wrong");
	skip_seen_c: cover property (@(posedge clk_i) taken && skip_q);
	add_carry_c: cover property (@(posedge clk_i)
		exec && instr_i[11:6] == 6'b0001_11 && add_sum[8]);
	wdt_seen_c: cover property (@(posedge clk_i) wdt_clear_o);
	port_swap_c: cover property (@(posedge clk_i)
		exec && port_we && to_acc);
endmodule : mlad_core

`default_nettype wire

/* File: verif/mlad_file_model.sv */
/*
 * File register memory facing the decoder: 32 bytes with a
 * combinational read and a write on the edge that ends the pulse.
 * Assumes the decoder keeps address 0x03 inside and never writes it.
 */
`default_nettype none

module mlad_file_model (
	input wire logic clk_i,
	input wire logic [4:0] addr_i,
	input wire mlad_pkg::mlad_file_wr_t wr_i,
	output logic [7:0] rdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:31];

	// Same-cycle read, so the decoder gets no extra wait state.
	assign rdata_o = mem[addr_i];

	// The bench presets bytes here, so this is not an always_ff.
	always @(posedge clk_i) begin
		if (wr_i.we) begin
			mem[wr_i.addr] <= wr_i.data;
		end
	end
endmodule : mlad_file_model

`default_nettype wire

/* File: verif/mlad_core_tb_top.sv */
/*
 * Self-checking bench for the decoder: one task per scenario.
 * Assumes the file model beside it and a 20 MHz core clock.
 */
`default_nettype none

module mlad_core_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [11:0] instr = 12'h000;
	logic valid = 1'b0;
	mlad_pkg::mlad_reg_req_t req = '0;
	mlad_pkg::mlad_file_wr_t fwr;
	wire logic ready;
	wire logic wdt;
	wire logic pre;
	wire logic [4:0] faddr;
	wire logic [7:0] frd;
	wire logic [7:0] rdata;
	wire logic [2:0] page;
	int n_mismatch = 0;
	int comparisons = 0;

	// Half period of 25 ns gives the 50 ns core cycle.
	always #25 clk_i = ~clk_i;

	mlad_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .instr_i(instr),
		.instr_valid_i(valid), .instr_ready_o(ready),
		.file_addr_o(faddr), .file_rdata_i(frd), .file_wr_o(fwr),
		.wdt_clear_o(wdt), .prescaler_clear_o(pre),
		.page_select_o(page), .reg_req_i(req), .reg_rdata_o(rdata));

	mlad_file_model mem_u (.clk_i(clk_i), .addr_i(faddr), .wr_i(fwr),
		.rdata_o(frd));

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : conclude

	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		req <= {1'b1, 1'b0, a, d};
		@(posedge clk_i);
		req <= '0;
	endtask : reg_wr

	// Read data stand only in the cycle after the strobe.
	task automatic reg_rd(input logic [7:0] a, input logic [7:0] e,
		input string what);
		@(posedge clk_i);
		req <= {1'b0, 1'b1, a, 8'h00};
		@(posedge clk_i);
		req <= '0;
		@(negedge clk_i);
		chk(rdata, e, what);
	endtask : reg_rd

	// Ready is combinational, so it is judged at the falling edge.
	task automatic exec(input logic [11:0] w);
		@(posedge clk_i);
		instr <= w;
		valid <= 1'b1;
		do @(negedge clk_i); while (ready !== 1'b1);
		@(posedge clk_i);
		valid <= 1'b0;
	endtask : exec

	task automatic wr_chk(input logic [4:0] a, input logic [7:0] d);
		@(negedge clk_i);
		chk({7'h00, fwr.we}, 8'h01, "write strobe");
		chk({3'h0, fwr.addr}, {3'h0, a}, "write addr");
		chk(fwr.data, d, "write data");
	endtask : wr_chk

	task automatic t_reset();
		chk({5'h00, page}, 8'h00, "page");
		reg_rd(8'h02, 8'h18, "status");
		reg_rd(8'h03, 8'h00, "mode");
		reg_rd(8'h04, 8'hFF, "option");
		reg_rd(8'h00, 8'h02, "ctrl");
		reg_rd(8'h01, 8'h00, "acc");
		reg_rd(8'h20, 8'h00, "unmapped");
		$display("reset values checked");
	endtask : t_reset

	task automatic t_divider();
		int n;
		n = 0;
		repeat (8) begin
			@(negedge clk_i);
			n += (ready === 1'b1);
		end
		chk(n[7:0], 8'h02, "slow ready");
		reg_wr(8'h00, 8'h03);
		n = 0;
		repeat (8) begin
			@(negedge clk_i);
			n += (ready === 1'b1);
		end
		chk(n[7:0], 8'h08, "fast ready");
		$display("divider checked");
	endtask : t_divider

	task automatic t_logic();
		exec(12'hC3C);
		exec(12'h108);
		reg_rd(8'h01, 8'h3F, "or acc");
		exec(12'h168);
		wr_chk(5'h08, 8'h0F);
		exec(12'hE0F);
		exec(12'hDF0);
		exec(12'hFFF);
		reg_rd(8'h01, 8'h00, "literal acc");
		reg_rd(8'h02, 8'h1C, "literal z");
		exec(12'hC55);
		reg_rd(8'h01, 8'h55, "load acc");
		reg_rd(8'h02, 8'h1C, "load flags");
		$display("logic checked");
	endtask : t_logic

	task automatic t_arith();
		reg_wr(8'h00, 8'h01);
		exec(12'hCFF);
		exec(12'h1C9);
		reg_rd(8'h01, 8'h00, "add acc");
		reg_rd(8'h02, 8'h1F, "add flags");
		exec(12'h1C9);
		reg_rd(8'h01, 8'h02, "carry add");
		reg_rd(8'h02, 8'h18, "carry flags");
		exec(12'h0A9);
		wr_chk(5'h09, 8'hFE);
		reg_rd(8'h02, 8'h18, "sub flags");
		$display("arithmetic checked");
	endtask : t_arith

	task automatic t_step();
		exec(12'h2AA);
		wr_chk(5'h0A, 8'h00);
		exec(12'h2EB);
		wr_chk(5'h0B, 8'h00);
		exec(12'hC77);
		reg_rd(8'h01, 8'h02, "skipped load");
		reg_rd(8'h02, 8'h1C, "step flags");
		exec(12'h5EC);
		wr_chk(5'h0C, 8'h80);
		exec(12'h7EC);
		exec(12'hC66);
		reg_rd(8'h01, 8'h02, "bit skip");
		exec(12'h6EC);
		exec(12'hC66);
		reg_rd(8'h01, 8'h66, "no skip");
		$display("step and bit checked");
	endtask : t_step

	task automatic t_wdt();
		reg_wr(8'h00, 8'h07);
		exec(12'h004);
		@(negedge clk_i);
		chk({6'h00, wdt, pre}, 8'h03, "wdt pulses");
		reg_rd(8'h02, 8'h1C, "wdt flags");
		$display("watchdog checked");
	endtask : t_wdt

	task automatic t_mode();
		exec(12'h05A);
		reg_rd(8'h03, 8'h0A, "mode");
		exec(12'h042);
		reg_rd(8'h01, 8'h0A, "mode acc");
		reg_rd(8'h02, 8'h1C, "mode flags");
		$display("mode checked");
	endtask : t_mode

	task automatic t_rot();
		exec(12'h36D);
		wr_chk(5'h0D, 8'h02);
		reg_rd(8'h02, 8'h1D, "rotate c");
		exec(12'h3AD);
		wr_chk(5'h0D, 8'h20);
		reg_rd(8'h02, 8'h1D, "swap flags");
		$display("rotate and swap checked");
	endtask : t_rot

	// Moves, clears, tests and port control, run in fast mode without
	// carry chaining as the watchdog scenario leaves it.
	task automatic t_move();
		exec(12'h02E);
		wr_chk(5'h0E, 8'h0A);
		exec(12'h26E);
		wr_chk(5'h0E, 8'hF5);
		reg_rd(8'h02, 8'h19, "not flags");
		exec(12'h20E);
		reg_rd(8'h01, 8'hF5, "load file");
		exec(12'h22A);
		wr_chk(5'h0A, 8'h00);
		reg_rd(8'h02, 8'h1D, "test flags");
		exec(12'h0E9);
		wr_chk(5'h09, 8'hFD);
		exec(12'h089);
		reg_rd(8'h01, 8'h08, "sub acc");
		reg_rd(8'h02, 8'h1B, "sub acc flags");
		exec(12'h2CF);
		reg_rd(8'h05, 8'h01, "skip pending");
		exec(12'hC77);
		reg_rd(8'h01, 8'h00, "move skip acc");
		reg_rd(8'h02, 8'h1B, "move skip flags");
		exec(12'h06E);
		wr_chk(5'h0E, 8'h00);
		exec(12'hC33);
		exec(12'h040);
		reg_rd(8'h01, 8'h00, "clear acc");
		reg_rd(8'h02, 8'h1F, "clear flags");
		exec(12'hC42);
		exec(12'h002);
		reg_rd(8'h04, 8'h42, "option write");
		exec(12'h043);
		reg_rd(8'h03, 8'h02, "mode from acc");
		exec(12'h05A);
		exec(12'h005);
		exec(12'h056);
		exec(12'hC99);
		exec(12'h005);
		reg_rd(8'h01, 8'h42, "port exchange");
		exec(12'h052);
		exec(12'h005);
		reg_rd(8'h01, 8'h99, "port read");
		$display("move and port control checked");
	endtask : t_move

	// Scenarios run in order; each depends on the state left before it.
	initial begin
		for (int i = 0; i < 32; i++) begin
			mem_u.mem[i] = 8'h00;
		end
		mem_u.mem[8] = 8'h0F;
		mem_u.mem[9] = 8'h01;
		mem_u.mem[10] = 8'hFF;
		mem_u.mem[11] = 8'h01;
		mem_u.mem[13] = 8'h81;
		mem_u.mem[15] = 8'h01;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_divider();
		t_logic();
		t_arith();
		t_step();
		t_wdt();
		t_mode();
		t_rot();
		t_move();
		conclude();
	end

	// The tests need a few hundred cycles; this is ample margin.
	initial begin
		#100000;
		n_mismatch++;
		conclude();
	end
endmodule : mlad_core_tb_top

`default_nettype wire
